// ### rtl/pscm_top.sv
// strap sampling, pll mode decode and clock output control
// assumes clk is the oscillator clock, equal to the crystal rate,
// and sys_rst is the total system reset (reset and halt asserted)
// What this block does
// - supply low: bypass pll, pin is port
// - supply high: sample pin as mode strap
// - after reset pin returns to port use
// - strap low gives multiply factor four
// - strap high gives multiply factor 401
// - clock output drive third, two-thirds, full, off
// - output clock also clocks core and logic
// - oscillator runs at crystal rate, undivided
`timescale 1ns/10ps
`include "pscm_defines.svh"

module pscm_top
	import pscm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        pll_supply_select,
	input  wire logic        clock_mode_pin_i,
	output logic             clock_mode_pin_o,
	output logic             clock_mode_pin_oe_n,
	output logic             pll_enable,
	output logic [11:0]      pll_multiply_field,
	output logic             system_clock_select_ext,
	output logic [1:0]       clock_output_drive,
	output logic             clock_output_enable,
	output logic             core_clock_gate,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	// ========================================================
	// input synchronisers
	logic        sup_s1_r;
	logic        sup_s2_r;
	logic        pin_s1_r;
	logic        pin_s2_r;

	// no reset: the pins must be tracked while reset is held,
	// so the synchronised levels are valid at the latch edge
	always_ff @(posedge clk) begin
		sup_s1_r <= pll_supply_select;
		sup_s2_r <= sup_s1_r;
		pin_s1_r <= clock_mode_pin_i;
		pin_s2_r <= pin_s1_r;
	end

	// ========================================================
	// phase after reset release
	pscm_phase_t phase_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			phase_r <= PSCM_PH_RESET;
		else begin
			case (phase_r)
			PSCM_PH_RESET: phase_r <= PSCM_PH_LATCH;
			PSCM_PH_LATCH: phase_r <= PSCM_PH_RUN;
			PSCM_PH_RUN:   phase_r <= PSCM_PH_RUN;
			default:       phase_r <= PSCM_PH_RESET;
			endcase
		end
	end

	// ========================================================
	// strap capture at release, held until next reset
	logic        supply_r;
	logic        strap_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			supply_r <= 1'b0;
			strap_r  <= 1'b0;
		end else if (phase_r == PSCM_PH_LATCH) begin
			// pin sampled while still held by the board
			supply_r <= sup_s2_r;
			strap_r  <= sup_s2_r & pin_s2_r;
		end
	end

	// ========================================================
	// pll mode decode
	function automatic logic [11:0] mf_decode(input logic sup,
		input logic strap);
		if (!sup)
			mf_decode = `PSCM_MF_NONE;
		else if (strap)
			mf_decode = `PSCM_MF_WATCH;
		else
			mf_decode = `PSCM_MF_LOW;
	endfunction

	logic [11:0] mf_r;
	logic        pll_en_r;
	logic        ext_sel_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mf_r      <= `PSCM_MF_NONE;
			pll_en_r  <= 1'b0;
			ext_sel_r <= 1'b1;
		end else if (phase_r == PSCM_PH_LATCH) begin
			mf_r      <= mf_decode(sup_s2_r, pin_s2_r);
			pll_en_r  <= sup_s2_r;
			ext_sel_r <= ~sup_s2_r;
		end
	end

	assign pll_enable              = pll_en_r;
	assign pll_multiply_field      = mf_r;
	// oscillator passes crystal rate straight on
	assign system_clock_select_ext = ext_sel_r;

	// ========================================================
	// control register
	logic [3:0]  ctrl_r;
	logic        apb_wr;
	logic        apb_rd;

	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl_r <= `PSCM_CTRL_RST;
		else if (apb_wr && paddr == `PSCM_OFF_CTRL)
			ctrl_r <= pwdata[3:0];
	end

	// ========================================================
	// clock output drive
	logic [1:0]  drv_r;
	logic        clock_output_en_r;
	logic        core_gate_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_r       <= `PSCM_DRV_RST;
			clock_output_en_r   <= 1'b1;
			core_gate_r <= 1'b1;
		end else begin
			drv_r       <= ctrl_r[`PSCM_CTRL_DRV_MSB:`PSCM_CTRL_DRV_LSB];
			clock_output_en_r   <= (ctrl_r[1:0] != PSCM_DRV_OFF);
			// core keeps the same clock when the pin is off
			core_gate_r <= 1'b1;
		end
	end

	assign clock_output_drive  = drv_r;
	assign clock_output_enable = clock_output_en_r;
	assign core_clock_gate     = core_gate_r;

	// ========================================================
	// shared pin: input during reset, port after
	logic        pin_o_r;
	logic        pin_oe_n_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_o_r    <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end else if (phase_r == PSCM_PH_RUN) begin
			pin_o_r    <= ctrl_r[`PSCM_CTRL_PAOUT];
			pin_oe_n_r <= ~ctrl_r[`PSCM_CTRL_PADIR];
		end
	end

	assign clock_mode_pin_o    = pin_o_r;
	assign clock_mode_pin_oe_n = pin_oe_n_r;

	// ========================================================
	// apb read and answer
	logic [31:0] rd_r;
	logic        rdy_r;
	logic        err_r;
	logic [31:0] rd_nxt;
	logic        hit;

	always_comb begin
		rd_nxt = `PSCM_WORD_ZERO;
		hit    = 1'b1;
		case (paddr)
		`PSCM_OFF_CTRL:   rd_nxt[3:0] = ctrl_r;
		`PSCM_OFF_STATUS: begin
			rd_nxt[`PSCM_ST_PLL_EN] = pll_en_r;
			rd_nxt[`PSCM_ST_STRAP]  = strap_r;
			rd_nxt[`PSCM_ST_SUPPLY] = supply_r;
			rd_nxt[`PSCM_ST_PIN]    = pin_s2_r;
		end
		`PSCM_OFF_PORTA:  rd_nxt[0] = pin_s2_r;
		`PSCM_OFF_MULT:   rd_nxt[11:0] = mf_r;
		default:          hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_r  <= `PSCM_WORD_ZERO;
			rdy_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			rdy_r <= psel & ~penable;
			err_r <= psel & ~penable & ~hit;
			if (psel && !penable && !pwrite && hit)
				rd_r <= rd_nxt;
			else if (!apb_rd)
				rd_r <= `PSCM_WORD_ZERO;
		end
	end

	assign prdata  = rd_r;
	assign pready  = rdy_r;
	assign pslverr = err_r;

endmodule

// ### rtl/pscm_defines.svh
// constants for the strap and clock mode block
// assumes inclusion by bare name from rtl files
`ifndef PSCM_DEFINES_SVH
`define PSCM_DEFINES_SVH

// ============================================================
// register map
`define PSCM_OFF_CTRL      12'h000
`define PSCM_OFF_STATUS    12'h004
`define PSCM_OFF_PORTA     12'h008
`define PSCM_OFF_MULT      12'h00C

// ============================================================
// field positions
`define PSCM_CTRL_DRV_LSB  0
`define PSCM_CTRL_DRV_MSB  1
`define PSCM_CTRL_PADIR    2
`define PSCM_CTRL_PAOUT    3
`define PSCM_ST_PLL_EN     0
`define PSCM_ST_STRAP      1
`define PSCM_ST_SUPPLY     2
`define PSCM_ST_PIN        3

// ============================================================
// reset values and multiply field defaults (field = factor - 1)
`define PSCM_CTRL_RST      4'h3
`define PSCM_DRV_RST       2'h3
`define PSCM_MF_LOW        12'h003
`define PSCM_MF_WATCH      12'h190
`define PSCM_MF_NONE       12'h000
`define PSCM_WORD_ZERO     32'h00000000

`endif

// ### rtl/pscm_pkg.sv
// types for the strap and clock mode block
// assumes the defines header is compiled alongside
package pscm_pkg;

	// ========================================================
	// clock output drive settings
	typedef enum logic [1:0] {
		PSCM_DRV_OFF,
		PSCM_DRV_THIRD,
		PSCM_DRV_TWO_THIRDS,
		PSCM_DRV_FULL
	} pscm_drive_t;

	// ========================================================
	// reset time phase
	typedef enum logic [1:0] {
		PSCM_PH_RESET,
		PSCM_PH_LATCH,
		PSCM_PH_RUN
	} pscm_phase_t;

endpackage

// ### verif/pscm_asserts.sv
// checker for the strap and clock mode block
// assumes binding to pscm_top ports
`timescale 1ns/10ps
module pscm_asserts (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        pll_enable,
	input wire logic [11:0] pll_multiply_field,
	input wire logic        system_clock_select_ext,
	input wire logic [1:0]  clock_output_drive,
	input wire logic        clock_output_enable,
	input wire logic        core_clock_gate,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr
);
	// ==========================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	bypass_mf_a: assert property (!pll_enable |->
		pll_multiply_field == 12'h000 && system_clock_select_ext)
		else $error("bypass mode wrong");
	pll_path_a: assert property (pll_enable |-> !system_clock_select_ext)
		else $error("pll path wrong");
	mf_value_a: assert property (pll_enable |->
		pll_multiply_field inside {12'h003, 12'h190})
		else $error("multiply field wrong");
	mode_hold_a: assert property (pll_enable |=>
		pll_enable && $stable(pll_multiply_field))
		else $error("pll mode changed");
	drive_off_a: assert property (clock_output_enable ==
		(clock_output_drive != 2'h0))
		else $error("clock output enable wrong");
	core_gate_a: assert property (core_clock_gate)
		else $error("core clock gated");
	apb_answer_a: assert property (psel && !penable |=> answer_s)
		else $error("bus answer late");
	err_ready_a: assert property (pslverr |-> pready && psel)
		else $error("error outside answer");
endmodule
bind pscm_top pscm_asserts pscm_asserts_inst (.clk, .sys_rst, .pll_enable,
	.pll_multiply_field, .system_clock_select_ext, .clock_output_drive,
	.clock_output_enable, .core_clock_gate, .psel, .penable, .pready,
	.pslverr);

// ### verif/pscm_board.sv
// board strap and supply wiring model
// assumes the bench sets the strap during reset and flips it only after the latch
`timescale 1ns/10ps
module pscm_board (
	input  wire logic supply_cfg,
	input  wire logic strap_cfg,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	output logic      supply,
	output logic      pin
);
	assign supply = supply_cfg;
	assign pin    = pin_oe_n ? strap_cfg : pin_o;
endmodule

// ### verif/tb.sv
// bench for the strap and clock mode block
// assumes pscm_top, board model and checker compiled before
`timescale 1ns/10ps
module tb;
	logic        clk = 0, sys_rst = 1, sup = 0, strap = 0;
	logic        psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, mf, v;
	logic        pready, pslverr, supply, pin, pin_o, oe_n, pll_en, ext;
	logic        oen, gate;
	logic [11:0] mfo;
	logic [1:0]  drv;
	int          mismatches = 0, total_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	pscm_board pscm_board_inst (.supply_cfg(sup), .strap_cfg(strap),
		.pin_o(pin_o), .pin_oe_n(oe_n), .supply(supply), .pin(pin));
	pscm_top pscm_top_inst (.clk, .sys_rst, .pll_supply_select(supply),
		.clock_mode_pin_i(pin), .clock_mode_pin_o(pin_o),
		.clock_mode_pin_oe_n(oe_n), .pll_enable(pll_en),
		.pll_multiply_field(mfo), .system_clock_select_ext(ext),
		.clock_output_drive(drv), .clock_output_enable(oen),
		.core_clock_gate(gate), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	// ==========================================
	// tasks
	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
		@(posedge clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		v = $urandom(666);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) sys_rst <= 1;
			sup <= k[1]; strap <= k[0];
			repeat (16) @(posedge clk);
			sys_rst <= 0;
			repeat (4) @(posedge clk);
			strap <= ~k[0];
			repeat (2) @(posedge clk);
			mf = !k[1] ? 0 : (k[0] ? 401 - 1 : 4 - 1);
			chk("mf", mf, mfo);
			chk("pll", k[1], pll_en);
			chk("ext", !k[1], ext);
			apb(0, 12'h000, 0);
			chk("ctrl", 3, rd);
			apb(0, 12'h00C, 0);
			chk("mult", mf, rd);
			apb(0, 12'h004, 0);
			chk("status", {~k[0], k[1], k[1] & k[0], k[1]}, rd);
			apb(0, 12'h008, 0);
			chk("porta", {31'h0, ~k[0]}, rd);
			for (int d = 0; d < 4; d++) begin
				v = $urandom;
				apb(1, 12'h000, {28'h0, v[0], 1'b1, 2'(d)});
				@(negedge clk);
				chk("drv", d, drv);
				chk("oen", d != 0, oen);
				chk("port", {1'b0, v[0]}, {oe_n, pin});
				chk("gate", 1, gate);
			end
			apb(0, 12'h010, 0);
			chk("err", {1'b1, 32'h0}, {er, rd});
		end
		print_verdict();
	end
endmodule
